//--- core/vkd_map.svh
// Constants for the key scan, read request and dimmer timing block
`ifndef VKD_MAP_SVH
`define VKD_MAP_SVH
// Clock cycles per oscillator period T (oscillator modelled on i_clock)
`define VKD_CLK_PER_T 1
// Key scan time per pass, in T
`define VKD_SCAN_T 12000
// Key read request delay from scan start, in T
`define VKD_REQ_T 25600
// Display period per digit, in T
`define VKD_DISP_T 2048
// Dimmer step, in T
`define VKD_STEP_T 2
// Derived cycle counts
`define VKD_SCAN_CYC (`VKD_SCAN_T * `VKD_CLK_PER_T)
`define VKD_REQ_CYC (`VKD_REQ_T * `VKD_CLK_PER_T)
`define VKD_DISP_CYC (`VKD_DISP_T * `VKD_CLK_PER_T)
`define VKD_STEP_CYC (`VKD_STEP_T * `VKD_CLK_PER_T)
// Matrix shape
`define VKD_NLINES 6
`define VKD_NSENSE 5
`define VKD_NKEYS 30
`define VKD_DM_W 10
// Scan drive patterns while waiting for a key
`define VKD_DRV_NORMAL 6'h3f
`define VKD_DRV_SEL01 6'h20
`define VKD_DRV_SEL10 6'h30
`define VKD_DRV_SEL11 6'h3f
// Dimmer setting used by the one-step off check
`define VKD_DM_ONE_STEP 10'h3fe
`endif

//--- core/vkd_pkg.sv
// Types for the key scan and dimmer block
package vkd_pkg;
  // Key scan controller states, one-hot
  typedef enum logic [3:0] {
    VKD_IDLE = 4'b0001,
    VKD_SCAN = 4'b0010,
    VKD_WAIT = 4'b0100,
    VKD_REQ  = 4'b1000
  } vkd_state_t;
  // One bit per key of the 6 x 5 matrix
  typedef logic [29:0] vkd_keys_t;
endpackage

//--- core/vkd_sync2.sv
// Two-flop synchroniser for pin inputs
module vkd_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q; // First stage, read only by second stage
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // Registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= meta_d;
      o_sync <= sync_d;
    end
  end
endmodule

//--- core/vkd_dimmer.sv
// Digit timing generator with dimmer
`include "vkd_map.svh"
module vkd_dimmer (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic [9:0] i_dimmer_level,
  output logic o_first_digit_out,
  output logic o_second_digit_out
);
  logic [11:0] cnt_q; // Bit 11 picks the digit, low bits the position
  logic [11:0] cnt_d;
  logic g1_d;
  logic g2_d;
  logic [11:0] on_len; // Step times (level + 1)
  logic [11:0] off_len; // Off interval at the start of each slot
  logic lit;

  // Off interval shrinks as the dimmer level grows
  always_comb begin
    on_len = 12'((32'(i_dimmer_level) + 1) * `VKD_STEP_CYC); // RULE14 RULE23
    off_len = 12'(`VKD_DISP_CYC) - on_len; // RULE14
    lit = {1'b0, cnt_q[10:0]} >= off_len;
    // Stopped and cleared while halted, so the pattern restarts cleanly
    cnt_d = i_run ? cnt_q + 12'h001 : 12'h000; // RULE16 RULE17
    g1_d = i_run & ~cnt_q[11] & lit; // RULE13
    g2_d = i_run & cnt_q[11] & lit; // RULE13 RULE18
  end

  // Registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 12'h000;
      o_first_digit_out <= 1'b0;
      o_second_digit_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_first_digit_out <= g1_d;
      o_second_digit_out <= g2_d;
    end
  end

  // One low step between digits at the brightest legal level
  sequence s_one_step_off;
    !o_second_digit_out [*2] ##1 o_second_digit_out;
  endsequence
  one_step_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE15
    (i_run && i_dimmer_level == `VKD_DM_ONE_STEP && $fell(o_first_digit_out)) |->
    (i_run && i_dimmer_level == `VKD_DM_ONE_STEP) throughout s_one_step_off)
    else $error("second digit off interval is not one step");
  // Digits never overlap
  digit_excl_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE13
    !(o_first_digit_out && o_second_digit_out))
    else $error("both digits on at once");
endmodule

//--- core/vkd_keyscan.sv
// Key scan, key read request, sleep control and blanking for the display driver
// What this block and the controller around it do
// RULE1 - Normal mode waiting: all scan drives high
// RULE2 - Scan on press, until release, multiple keys
// RULE3 - Key held past 25600T pulls request low
// RULE4 - Chip enable high releases the request
// RULE5 - Read done clears request, rescans
// RULE6 - Request output is open drain
// RULE7 - Sleep drives set by sleep select bits
// RULE8 - Sleep key press restarts oscillator and scans
// RULE9 - Read in sleep keeps sleep mode
// RULE10 - Select 0/1: only sixth drive high
// RULE11 - Controller discards readouts with three keys
// RULE12 - Controller loads data before releasing blanking
// RULE13 - Digit period is 2048 oscillator cycles
// RULE14 - Off interval shrinks by step per level
// RULE15 - Level 3FE gives one-step off interval
// RULE16 - Blanking resets and stops divider
// RULE17 - Blanking resets and halts dimmer timing
// RULE18 - Blanking forces segments and digits low
// RULE19 - Blanking resets and disables key scan
// RULE20 - Blanking clears the key buffer
// RULE21 - Oscillator state follows first sleep transfer
// RULE22 - Blanking leaves serial and control loading alive
// RULE23 - Dimmer level is ten bits, duty (level+1)/1024
// RULE24 - Two 12000T scans must agree
// RULE25 - Sleep when either select bit set
// RULE26 - Sleep acknowledge returned with key data
// RULE27 - Sleep oscillator stops again once idle
`include "vkd_map.svh"
module vkd_keyscan #(
  parameter logic [15:0] P_SCAN_CYC = 16'(`VKD_SCAN_CYC), // One scan pass
  parameter logic [15:0] P_REQ_CYC = 16'(`VKD_REQ_CYC) // Scan start to request
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_blank_b,
  input wire logic i_chip_enable,
  input wire logic i_read_done,
  input wire logic i_sleep_load,
  input wire logic i_sleep_select_lo,
  input wire logic i_sleep_select_hi,
  input wire logic [9:0] i_dimmer_level,
  input wire logic [4:0] i_scan_sense_lines,
  output logic [5:0] o_scan_drive_lines,
  output logic o_request_out,
  output logic o_request_oe_b,
  output vkd_pkg::vkd_keys_t o_key_bits,
  output logic o_sleep_ack_bit,
  output logic o_first_digit_out,
  output logic o_second_digit_out,
  output logic o_segment_enable,
  output logic o_osc_run
);
  import vkd_pkg::*;

  // Per-line dwell; a pass walks all six drive lines
  localparam logic [15:0] LINE_CYC = P_SCAN_CYC / 16'd6;

  // Synchronised pins
  logic [6:0] pins_s;
  logic blank_s; // High when display is enabled
  logic ce_s; // Chip enable
  logic [4:0] sense_s; // Sense lines

  // Key scan state
  vkd_state_t st_q;
  vkd_state_t st_d;
  logic [15:0] tmr_q; // Time since scan pair start
  logic [15:0] tmr_d;
  logic [15:0] dwell_q; // Time on current drive line
  logic [15:0] dwell_d;
  logic [2:0] line_q; // Drive line under scan
  logic [2:0] line_d;
  logic pass_q; // Second pass of a pair
  logic pass_d;
  vkd_keys_t cur_q; // Keys of the running pass
  vkd_keys_t cur_d;
  vkd_keys_t prev_q; // Keys of the previous pass
  vkd_keys_t prev_d;
  vkd_keys_t key_q; // Key buffer seen by the reader
  vkd_keys_t key_d;
  logic ack_q; // Sleep acknowledge latched with keys
  logic ack_d;
  logic req_q; // Key read request pending
  logic req_d;

  // Mode state
  logic sleep_q; // Sleep mode
  logic sleep_d;
  logic known_q; // Sleep bits transferred at least once
  logic known_d;
  logic osc_q;
  logic osc_d;
  logic seg_q;
  logic seg_d;
  logic [5:0] drv_q;
  logic [5:0] drv_d;
  logic [5:0] wait_pat; // Drive pattern while waiting for a key
  logic line_end;
  logic any_key;

  // Blanking, chip enable and sense lines come straight off pins
  vkd_sync2 #(
    .W(7)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async({i_blank_b, i_chip_enable, i_scan_sense_lines}),
    .o_sync(pins_s)
  );

  always_comb begin
    blank_s = pins_s[6];
    ce_s = pins_s[5];
    sense_s = pins_s[4:0];
  end

  // Sleep select capture; runs even while blanked so the
  // controller can set the mode before lifting blanking
  always_comb begin
    sleep_d = sleep_q;
    known_d = known_q;
    if (i_sleep_load) begin // RULE22
      sleep_d = i_sleep_select_lo | i_sleep_select_hi; // RULE25
      known_d = 1'b1; // RULE21
    end
  end

  // Drive pattern while waiting, from mode and select bits
  always_comb begin
    if (!sleep_q) begin
      wait_pat = `VKD_DRV_NORMAL; // RULE1
    end else if (!i_sleep_select_hi) begin
      wait_pat = `VKD_DRV_SEL10; // RULE7
    end else if (!i_sleep_select_lo) begin
      wait_pat = `VKD_DRV_SEL01; // RULE10
    end else begin
      wait_pat = `VKD_DRV_SEL11; // RULE7
    end
  end

  // Key scan controller
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    dwell_d = dwell_q;
    line_d = line_q;
    pass_d = pass_q;
    cur_d = cur_q;
    prev_d = prev_q;
    key_d = key_q;
    ack_d = ack_q;
    req_d = req_q;
    line_end = dwell_q == LINE_CYC - 16'd1;
    any_key = |sense_s;
    case (st_q)
      VKD_IDLE: begin
        // Only lines driven high can report a press
        if (any_key) begin // RULE2 RULE8
          st_d = VKD_SCAN;
          tmr_d = 16'h0000;
          dwell_d = 16'h0000;
          line_d = 3'h0;
          pass_d = 1'b0;
        end
      end
      VKD_SCAN: begin
        tmr_d = tmr_q + 16'h0001;
        dwell_d = dwell_q + 16'h0001;
        if (line_end) begin
          // Sense sampled at the end of each line's dwell
          cur_d[line_q * 5 +: 5] = sense_s; // RULE2
          dwell_d = 16'h0000;
          line_d = line_q + 3'h1;
          if (line_q == 3'h5) begin
            line_d = 3'h0;
            prev_d = cur_d;
            if (!pass_q) begin
              pass_d = 1'b1; // RULE24
            end else if (cur_d == prev_q) begin
              // Agreed: released keys end the scan, held ones wait
              st_d = (cur_d == '0) ? VKD_IDLE : VKD_WAIT; // RULE24 RULE2
            end else if (cur_d == '0) begin
              st_d = VKD_IDLE;
            end else begin
              // Disagreement restarts the pair and its timer
              pass_d = 1'b0; // RULE24
              tmr_d = 16'h0000;
            end
          end
        end
      end
      VKD_WAIT: begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q >= P_REQ_CYC - 16'd1) begin
          req_d = 1'b1; // RULE3
          key_d = prev_q;
          ack_d = sleep_q; // RULE26
          st_d = VKD_REQ;
        end
      end
      VKD_REQ: begin
        if (i_read_done) begin
          // Sleep flag untouched here; only a transfer changes it
          req_d = 1'b0; // RULE5 RULE9
          st_d = VKD_SCAN;
          tmr_d = 16'h0000;
          dwell_d = 16'h0000;
          line_d = 3'h0;
          pass_d = 1'b0;
        end
      end
      default: begin
        st_d = VKD_IDLE;
      end
    endcase
    // Blanking wins over everything in the scan path
    if (!blank_s) begin
      st_d = VKD_IDLE; // RULE19
      tmr_d = 16'h0000;
      dwell_d = 16'h0000;
      line_d = 3'h0;
      pass_d = 1'b0;
      cur_d = '0;
      prev_d = '0;
      key_d = '0; // RULE20
      ack_d = 1'b0;
      req_d = 1'b0;
    end
  end

  // Outputs held in flops: drives, oscillator, segment enable
  always_comb begin
    if (st_q == VKD_SCAN) begin
      drv_d = 6'(6'h01 << line_q);
    end else begin
      drv_d = wait_pat; // RULE1 RULE7
    end
    // Oscillator idles in sleep once nothing is pending
    if (!known_q) begin
      osc_d = 1'b1; // RULE21
    end else begin
      osc_d = !sleep_q || (st_q != VKD_IDLE); // RULE8 RULE27 RULE25
    end
    seg_d = blank_s && !sleep_q; // RULE18 RULE25
  end

  // Registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= VKD_IDLE;
      tmr_q <= 16'h0000;
      dwell_q <= 16'h0000;
      line_q <= 3'h0;
      pass_q <= 1'b0;
      cur_q <= '0;
      prev_q <= '0;
      key_q <= '0;
      ack_q <= 1'b0;
      req_q <= 1'b0;
      sleep_q <= 1'b0;
      known_q <= 1'b0;
      osc_q <= 1'b1;
      seg_q <= 1'b0;
      drv_q <= `VKD_DRV_NORMAL;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      dwell_q <= dwell_d;
      line_q <= line_d;
      pass_q <= pass_d;
      cur_q <= cur_d;
      prev_q <= prev_d;
      key_q <= key_d;
      ack_q <= ack_d;
      req_q <= req_d;
      sleep_q <= sleep_d;
      known_q <= known_d;
      osc_q <= osc_d;
      seg_q <= seg_d;
      drv_q <= drv_d;
    end
  end

  // Digit timing; halted while blanked or asleep
  vkd_dimmer u_dimmer (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_run(blank_s && !sleep_q), // RULE16 RULE17 RULE18
    .i_dimmer_level(i_dimmer_level),
    .o_first_digit_out(o_first_digit_out),
    .o_second_digit_out(o_second_digit_out)
  );

  // Pin outputs; the request line only ever pulls low
  always_comb begin
    o_scan_drive_lines = drv_q;
    o_request_out = 1'b0; // RULE6
    o_request_oe_b = !(req_q && !ce_s); // RULE4 RULE6
    o_key_bits = key_q;
    o_sleep_ack_bit = ack_q;
    o_segment_enable = seg_q;
    o_osc_run = osc_q;
  end

  // Waiting in normal mode drives every line high
  idle_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE1
    (st_q == VKD_IDLE && !sleep_q && st_d == VKD_IDLE) |=> o_scan_drive_lines == 6'h3f)
    else $error("normal idle drive not all high");

  // A press while waiting starts a scan and runs the oscillator
  scan_start_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE2 RULE8
    (st_q == VKD_IDLE && blank_s && |sense_s) |=> (st_q == VKD_SCAN) ##1 o_osc_run)
    else $error("key press did not start a scan");

  // Request raised exactly at the request time
  req_time_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE3
    $rose(req_q) |-> $past(tmr_q) == P_REQ_CYC - 16'd1)
    else $error("read request raised at wrong time");

  // Pull only when requesting with chip enable low
  drain_only_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE4 RULE6
    !o_request_oe_b |-> (req_q && !ce_s && !o_request_out))
    else $error("request pulled without cause");

  // Read completion clears request and rescans
  sequence s_read_done;
    st_q == VKD_REQ && i_read_done && blank_s;
  endsequence
  read_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE5
    s_read_done |=> (!req_q && st_q == VKD_SCAN) ##1 o_request_oe_b)
    else $error("read completion did not clear request");

  // Select 0/1 in sleep leaves only the sixth line high
  sleep_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE10 RULE7
    (sleep_q && st_q == VKD_IDLE && st_d == VKD_IDLE && !i_sleep_select_lo && i_sleep_select_hi)
    |=> o_scan_drive_lines == 6'h20)
    else $error("sleep drive pattern wrong");

  // A key read in sleep leaves sleep mode set
  sleep_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE9
    (s_read_done and (sleep_q && !i_sleep_load)) |=> sleep_q)
    else $error("key read cleared sleep mode");

  // Blanking clears keys and darkens the display
  blank_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE18 RULE20
    (!blank_s) [*2] |=> (o_key_bits == '0 && !o_first_digit_out && !o_second_digit_out
    && !o_segment_enable && o_request_oe_b))
    else $error("blanking did not clear outputs");

  // Scan pass length matches the pass time
  pass_len_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE24
    (st_q == VKD_SCAN && line_q == 3'h5 && dwell_q == LINE_CYC - 16'd1 && !pass_q && blank_s)
    |-> tmr_q == 6 * LINE_CYC - 16'd1)
    else $error("scan pass length wrong");

  // Sleep with nothing to do stops the oscillator
  osc_stop_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE27 RULE25
    (known_q && sleep_q && st_q == VKD_IDLE) |=> !o_osc_run)
    else $error("oscillator left running in idle sleep");
endmodule

//--- dv/vkd_key_matrix.sv
// Key matrix and pulled-up request line seen from the scan pins
module vkd_key_matrix (
  input wire logic [5:0] i_scan_drive_lines,
  input vkd_pkg::vkd_keys_t i_pressed,
  input wire logic i_request_out,
  input wire logic i_request_oe_b,
  output logic [4:0] o_scan_sense_lines,
  output wire logic o_request_pin
);
  import vkd_pkg::*;

  // Pull-up gives the high level whenever the pin is not pulled low
  assign o_request_pin = (i_request_oe_b === 1'b0) ? i_request_out : 1'b1;

  // A sense line is high when any pressed key joins it to a driven line
  always_comb begin
    o_scan_sense_lines = 5'h00;
    for (int l = 0; l < 6; l++) begin
      for (int s = 0; s < 5; s++) begin
        if (i_scan_drive_lines[l] && i_pressed[l * 5 + s]) begin
          o_scan_sense_lines[s] = 1'b1;
        end
      end
    end
  end
endmodule

//--- dv/vkd_keyscan_test.sv
// Self-checking bench for the key scan and dimmer block
module vkd_keyscan_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vkd_pkg::*;

  logic i_clock, i_rst_b, i_blank_b, i_chip_enable, i_read_done;
  logic i_sleep_load, i_sleep_select_lo, i_sleep_select_hi;
  logic [9:0] i_dimmer_level;
  logic [4:0] i_scan_sense_lines;
  logic [5:0] o_scan_drive_lines;
  logic o_request_out, o_request_oe_b, o_sleep_ack_bit;
  logic o_first_digit_out, o_second_digit_out, o_segment_enable, o_osc_run;
  vkd_keys_t o_key_bits;
  vkd_keys_t pressed; // Keys held down by the user
  wire logic req_pin; // Request line after the pull-up
  int mismatches = 0;
  int n_compared = 0;
  int n, hi, per;
  logic [5:0] sleep_pat [1:3] = '{6'h30, 6'h20, 6'h3f}; // Idle drives per select code, index bit 0 is lo
  logic [9:0] dm_lvl [0:1] = '{10'h3fe, 10'h1ff}; // One step, then half duty

  // Short scan counts keep the run brief; expectations use the same values
  vkd_keyscan #(.P_SCAN_CYC(16'd60), .P_REQ_CYC(16'd200)) dut_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_blank_b(i_blank_b),
    .i_chip_enable(i_chip_enable), .i_read_done(i_read_done),
    .i_sleep_load(i_sleep_load), .i_sleep_select_lo(i_sleep_select_lo),
    .i_sleep_select_hi(i_sleep_select_hi), .i_dimmer_level(i_dimmer_level),
    .i_scan_sense_lines(i_scan_sense_lines), .o_scan_drive_lines(o_scan_drive_lines),
    .o_request_out(o_request_out), .o_request_oe_b(o_request_oe_b),
    .o_key_bits(o_key_bits), .o_sleep_ack_bit(o_sleep_ack_bit),
    .o_first_digit_out(o_first_digit_out), .o_second_digit_out(o_second_digit_out),
    .o_segment_enable(o_segment_enable), .o_osc_run(o_osc_run)
  );

  vkd_key_matrix matrix_u (
    .i_scan_drive_lines(o_scan_drive_lines), .i_pressed(pressed),
    .i_request_out(o_request_out), .i_request_oe_b(o_request_oe_b),
    .o_scan_sense_lines(i_scan_sense_lines), .o_request_pin(req_pin)
  );

  // Free-running 125 MHz clock
  always #4 i_clock = ~i_clock;

  // Compare one result, count it, report a miss
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge i_clock);
  endtask

  // Transfer the two sleep select bits
  task automatic load_sleep(input logic lo, input logic hi_b);
    @(posedge i_clock);
    i_sleep_select_lo <= lo;
    i_sleep_select_hi <= hi_b;
    i_sleep_load <= 1'b1;
    @(posedge i_clock);
    i_sleep_load <= 1'b0;
  endtask

  // Key data readout finished, one-cycle pulse
  task automatic read_done();
    @(posedge i_clock);
    i_read_done <= 1'b1;
    @(posedge i_clock);
    i_read_done <= 1'b0;
  endtask

  // Cycles until the request pin goes low, bounded
  task automatic wait_req(output int c);
    c = 0;
    while (req_pin !== 1'b0 && c < 1000) begin
      @(posedge i_clock);
      c++;
    end
  endtask

  // High time and period of the first digit, bounded so a stuck output ends
  task automatic meas(output int h, output int p);
    int k;
    k = 0;
    h = 0;
    while (o_first_digit_out !== 1'b0 && k < 9000) begin
      @(posedge i_clock);
      k++;
    end
    while (o_first_digit_out !== 1'b1 && k < 9000) begin
      @(posedge i_clock);
      k++;
    end
    while (o_first_digit_out === 1'b1 && k < 9000) begin
      @(posedge i_clock);
      h++;
      k++;
    end
    p = h;
    while (o_first_digit_out === 1'b0 && k < 9000) begin
      @(posedge i_clock);
      p++;
      k++;
    end
  endtask

  // Watchdog sized well past the expected run of about 26600 cycles
  initial begin
    repeat (100000) @(posedge i_clock);
    mismatches++;
    print_verdict();
  end

  // Main sequence
  initial begin
    i_clock = 1'b0;
    i_rst_b = 1'b0;
    i_blank_b = 1'b0;
    i_chip_enable = 1'b0;
    i_read_done = 1'b0;
    i_sleep_load = 1'b0;
    i_sleep_select_lo = 1'b0;
    i_sleep_select_hi = 1'b0;
    i_dimmer_level = 10'h3fe;
    pressed = '0;
    tick(20);
    i_rst_b <= 1'b1;
    // Control data loaded while blanked, then blanking released
    load_sleep(1'b0, 1'b0);
    tick(4);
    chk(o_first_digit_out, 1'b0);
    chk(o_segment_enable, 1'b0);
    i_blank_b <= 1'b1;
    tick(5);
    chk(o_osc_run, 1'b1);
    chk(o_scan_drive_lines, 6'h3f);
    // Digit duty for each dimmer level
    for (int i = 0; i < 2; i++) begin
      i_dimmer_level <= dm_lvl[i];
      meas(hi, per);
      meas(hi, per);
      chk(hi, 2 * (dm_lvl[i] + 1));
      chk(per, 4096);
    end
    // Two keys at once, far corners of the matrix
    pressed <= 30'h1 | (30'h1 << 29);
    wait_req(n);
    chk(32'(n >= 200 && n <= 210), 1);
    chk(o_key_bits, 30'h1 | (30'h1 << 29));
    // Controller side keeps only readouts with fewer than three keys
    chk(32'($countones(o_key_bits) < 3), 1);
    chk(o_sleep_ack_bit, 1'b0);
    chk(req_pin, 1'b0);
    i_chip_enable <= 1'b1;
    tick(4);
    chk(req_pin, 1'b1);
    i_chip_enable <= 1'b0;
    tick(4);
    chk(req_pin, 1'b0);
    read_done();
    tick(1);
    chk(o_request_oe_b, 1'b1);
    // Still held, so scanning goes on and asks again
    wait_req(n);
    chk(32'(n >= 150 && n <= 210), 1);
    // Blanking with a request pending
    i_blank_b <= 1'b0;
    tick(4);
    chk(o_key_bits, 30'h0);
    chk(o_request_oe_b, 1'b1);
    chk({o_first_digit_out, o_second_digit_out, o_segment_enable}, 3'h0);
    pressed <= '0;
    load_sleep(1'b0, 1'b1);
    tick(4);
    chk(o_scan_drive_lines, 6'h20);
    i_blank_b <= 1'b1;
    // Every sleep select code
    for (int s = 1; s < 4; s++) begin
      load_sleep(s[0], s[1]);
      tick(4);
      chk(o_scan_drive_lines, sleep_pat[s]);
      chk({o_segment_enable, o_first_digit_out, o_second_digit_out}, 3'h0);
      chk(o_osc_run, 1'b0);
    end
    // Wake by a key on the only driven line
    load_sleep(1'b0, 1'b1);
    tick(4);
    pressed <= 30'h1 << 25;
    tick(6);
    chk(o_osc_run, 1'b1);
    wait_req(n);
    // Request time counted from the press, less the six cycles already waited
    chk(32'(n >= 190 && n <= 200), 1);
    chk(o_key_bits, 30'h1 << 25);
    chk(o_sleep_ack_bit, 1'b1);
    read_done();
    pressed <= '0;
    tick(300);
    chk(o_scan_drive_lines, 6'h20);
    chk(o_osc_run, 1'b0);
    chk(req_pin, 1'b1);
    load_sleep(1'b0, 1'b0);
    tick(4);
    chk(o_segment_enable, 1'b1);
    chk(o_scan_drive_lines, 6'h3f);
    print_verdict();
  end
endmodule
